// *** design/pscs_sequencer.sv ***
// Configuration sequencer for the passive serial scheme: reset, data and start-up stages.
// Assumes external pull-ups on the status and completion lines, and a host that keeps
// the serial clock still outside the data stage.
`timescale 1ns/1ps
module pscs_sequencer
    import pscs_pkg::*;
#(
    parameter int POR_CYC = POR_CYC_DEFAULT,
    parameter logic [31:0] CFG_WORDS = 32'h0000_0400
)(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cfgRequest_n,
    input wire logic cfgStatusIn_n,
    output logic cfgStatusOut_n,
    output logic cfgStatusOe,
    input wire logic cfgCompleteIn,
    output logic cfgCompleteOut,
    output logic cfgCompleteOe,
    input wire logic serialCfgClock,
    input wire logic serialCfgData,
    input wire logic userStartupClock,
    input wire logic autoRestartEn,
    input wire logic userClockEn,
    input wire logic compressEn,
    output pscs_word_t cfgWord,
    output logic cfgError,
    output logic userMode
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pscs_state_t state_q;
    logic [TIMER_W-1:0] timer_q;
    pscs_opt_t opt_q;
    logic [3:0] pinS1_q;
    logic [3:0] pinS2_q;
    logic [3:0] pinS3_q;
    logic [3:0] pinF_q;
    logic [3:0] pinF_d;
    logic reqPrev_q;
    logic uclkPrev_q;
    logic [UCLK_CNT_W-1:0] uclkCnt_q;
    logic linkRun_q;
    logic [WORD_W-1:0] linkWord;
    logic linkToggle;
    logic togS1_q;
    logic togS2_q;
    logic togS3_q;
    logic togAcc_q;
    logic wordEvent;
    logic syncSeen_q;
    logic escPend_q;
    logic [31:0] wordCnt_q;
    logic emitNow;
    logic [WORD_W-1:0] emitData;
    logic [WORD_W-1:0] emitRun;
    logic protoErr;
    logic lastWord;
    logic reqFall;
    logic reqHigh;
    logic statusHigh;
    logic completeHigh;
    logic uclkRise;
    pscs_word_t cfgWord_q;
    logic cfgError_q;
    logic userMode_q;
    logic statusOe_q;
    logic completeOe_q;

    // True once the shared timer has counted the given number of cycles.
    function automatic logic timerDone(input logic [TIMER_W-1:0] t, input int cycles);
        timerDone = (t >= TIMER_W'(cycles - 1));
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------

    // A filtered bit only follows the chain once the second and third stages agree,
    // which rejects a single-cycle glitch on the slow pull-up lines.
    assign pinF_d = (pinS2_q & ~(pinS2_q ^ pinS3_q)) | (pinF_q & (pinS2_q ^ pinS3_q));

    // Three-stage chain for the request, both line read-backs and the user clock.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pinS1_q <= PIN_RESET;
            pinS2_q <= PIN_RESET;
            pinS3_q <= PIN_RESET;
            pinF_q <= PIN_RESET;
        end else begin
            pinS1_q <= {userStartupClock, cfgCompleteIn, cfgStatusIn_n, cfgRequest_n};
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
            pinF_q <= pinF_d;
        end
    end

    // Edge history for the request line and the user start-up clock.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reqPrev_q <= 1'b0;
            uclkPrev_q <= 1'b0;
        end else begin
            reqPrev_q <= pinF_q[PIN_REQ];
            uclkPrev_q <= pinF_q[PIN_UCLK];
        end
    end

    assign reqHigh = pinF_q[PIN_REQ];
    assign reqFall = reqPrev_q & ~pinF_q[PIN_REQ];
    assign statusHigh = pinF_q[PIN_STATUS];
    assign completeHigh = pinF_q[PIN_COMPLETE];
    assign uclkRise = pinF_q[PIN_UCLK] & ~uclkPrev_q;

    // ------------------------------------------------------------------
    // Link receiver and word crossing
    // ------------------------------------------------------------------
    pscs_link_rx u_link_rx (
        .serialCfgClock(serialCfgClock),
        .linkRst_n(linkRun_q),
        .serialCfgData(serialCfgData),
        .linkWord(linkWord),
        .linkToggle(linkToggle)
    );

    // The toggle crosses through three stages; the holding register is only read once
    // the toggle has settled, so the word itself needs no synchroniser.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            togS1_q <= 1'b0;
            togS2_q <= 1'b0;
            togS3_q <= 1'b0;
            togAcc_q <= 1'b0;
        end else begin
            togS1_q <= linkToggle;
            togS2_q <= togS1_q;
            togS3_q <= togS2_q;
            if (togS2_q == togS3_q) begin
                togAcc_q <= togS2_q;
            end
        end
    end

    // Words are only taken while the link is armed; stale toggles from a reset are dropped.
    assign wordEvent = linkRun_q & (togS2_q == togS3_q) & (togS2_q != togAcc_q);

    // ------------------------------------------------------------------
    // Stream decoding and decompression
    // ------------------------------------------------------------------

    // The stream opens with a sync word. With compression on, an escape word followed by
    // a count stands for that many zero words, emitted as one beat with a repeat count.
    always_comb begin
        emitNow = 1'b0;
        emitData = linkWord;
        emitRun = {{(WORD_W-1){1'b0}}, 1'b1};
        protoErr = 1'b0;
        if (wordEvent) begin
            if (!syncSeen_q) begin
                protoErr = (linkWord != SYNC_WORD);
            end else if (opt_q.compressed && escPend_q) begin
                emitNow = (linkWord != '0);
                emitData = '0;
                emitRun = linkWord;
                protoErr = (linkWord == '0);
            end else if (!(opt_q.compressed && linkWord == RUN_ESCAPE)) begin
                emitNow = 1'b1;
            end
        end
    end

    // The last beat is the one that brings the expanded count up to the image size.
    assign lastWord = emitNow & ((wordCnt_q + {{(32-WORD_W){1'b0}}, emitRun}) >= CFG_WORDS);

    // Decoder state is cleared whenever the link is not receiving.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            syncSeen_q <= 1'b0;
            escPend_q <= 1'b0;
            wordCnt_q <= '0;
        end else if (state_q != SEQ_RECEIVE) begin
            syncSeen_q <= 1'b0;
            escPend_q <= 1'b0;
            wordCnt_q <= '0;
        end else if (wordEvent) begin
            syncSeen_q <= 1'b1;
            escPend_q <= syncSeen_q & opt_q.compressed & ~escPend_q & (linkWord == RUN_ESCAPE);
            if (emitNow) begin
                wordCnt_q <= wordCnt_q + {{(32-WORD_W){1'b0}}, emitRun};
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------

    // One shared timer serves every stage; it restarts on each change of state.
    // The power-on delay ignores the request line, as no restart is possible then.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= SEQ_POR;
            timer_q <= '0;
            opt_q <= '0;
        end else if (reqFall && state_q != SEQ_POR) begin
            state_q <= SEQ_RESET;
            timer_q <= '0;
        end else begin
            timer_q <= timer_q + 1'b1;
            case (state_q)
                SEQ_POR: begin
                    if (timerDone(timer_q, POR_CYC)) begin
                        state_q <= SEQ_RESET;
                        timer_q <= '0;
                    end
                end
                SEQ_RESET: begin
                    // Status stays low for the minimum width, longer while the host holds request low.
                    if (reqHigh && timerDone(timer_q, STATUS_MIN_CYC)) begin
                        state_q <= SEQ_RELEASE;
                        timer_q <= '0;
                    end
                end
                SEQ_RELEASE: begin
                    // Another device may still hold the line low; wait for it to rise.
                    if (statusHigh) begin
                        state_q <= SEQ_RECEIVE;
                        timer_q <= '0;
                        opt_q <= '{autoRestart: autoRestartEn, userClock: userClockEn,
                                   compressed: compressEn};
                    end
                end
                SEQ_RECEIVE: begin
                    if (protoErr || !statusHigh) begin
                        state_q <= SEQ_ERROR;
                        timer_q <= '0;
                    end else if (lastWord) begin
                        state_q <= SEQ_INITWAIT;
                        timer_q <= '0;
                    end
                end
                SEQ_ERROR: begin
                    // Without auto-restart only a request pulse leaves this state.
                    if (opt_q.autoRestart && timerDone(timer_q, ERR_HOLD_CYC)) begin
                        state_q <= SEQ_RELEASE;
                        timer_q <= '0;
                    end
                end
                SEQ_INITWAIT: begin
                    // All chained devices must be done before start-up is timed.
                    if (completeHigh) begin
                        state_q <= opt_q.userClock ? SEQ_CLKEN : SEQ_INITOSC;
                        timer_q <= '0;
                    end
                end
                SEQ_INITOSC: begin
                    if (timerDone(timer_q, INIT_OSC_CYC)) begin
                        state_q <= SEQ_USER;
                        timer_q <= '0;
                    end
                end
                SEQ_CLKEN: begin
                    if (timerDone(timer_q, CD2CU_CYC)) begin
                        state_q <= SEQ_USERCLK;
                        timer_q <= '0;
                    end
                end
                SEQ_USERCLK: begin
                    if (uclkRise && uclkCnt_q == UCLK_CNT_W'(USER_CLK_INIT_PERIODS - 1)) begin
                        state_q <= SEQ_USER;
                        timer_q <= '0;
                    end
                end
                SEQ_USER: begin
                    timer_q <= '0;
                end
                default: begin
                    state_q <= SEQ_POR;
                    timer_q <= '0;
                end
            endcase
        end
    end

    // Counts user start-up clock periods; the host must keep the clock running meanwhile.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            uclkCnt_q <= '0;
        end else if (state_q != SEQ_USERCLK) begin
            uclkCnt_q <= '0;
        end else if (uclkRise) begin
            uclkCnt_q <= uclkCnt_q + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Link arming and outputs
    // ------------------------------------------------------------------

    // The link reset is lifted only after the status line is seen high, well before the
    // host may send its first clock edge, so its release cannot meet a live edge.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            linkRun_q <= 1'b0;
        end else begin
            linkRun_q <= (state_q == SEQ_RECEIVE);
        end
    end

    // Open-drain drives: enables are high while the line is pulled low.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            statusOe_q <= 1'b1;
            completeOe_q <= 1'b1;
        end else begin
            statusOe_q <= (state_q == SEQ_POR) || (state_q == SEQ_RESET) || (state_q == SEQ_ERROR);
            completeOe_q <= (state_q == SEQ_POR) || (state_q == SEQ_RESET) || (state_q == SEQ_RELEASE) ||
                            (state_q == SEQ_RECEIVE) || (state_q == SEQ_ERROR);
        end
    end

    // Expanded words, the error flag and the user-mode indication.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfgWord_q <= '0;
            cfgError_q <= 1'b0;
            userMode_q <= 1'b0;
        end else begin
            cfgWord_q.valid <= emitNow && (state_q == SEQ_RECEIVE);
            if (emitNow) begin
                cfgWord_q.data <= emitData;
                cfgWord_q.repeatCount <= emitRun;
            end
            // The flag is held until the reset stage is next entered; an auto-restart leaves it set.
            if (state_q == SEQ_ERROR) begin
                cfgError_q <= 1'b1;
            end else if (state_q == SEQ_RESET) begin
                cfgError_q <= 1'b0;
            end
            userMode_q <= (state_q == SEQ_USER);
        end
    end

    assign cfgStatusOut_n = 1'b0;
    assign cfgCompleteOut = 1'b0;
    assign cfgStatusOe = statusOe_q;
    assign cfgCompleteOe = completeOe_q;
    assign cfgWord = cfgWord_q;
    assign cfgError = cfgError_q;
    assign userMode = userMode_q;

endmodule

// *** common/pscs_pkg.sv ***
// Shared constants and types for the passive serial configuration sequencer.
// Assumes a 40 MHz system clock; every cycle count below is derived from that rate.
package pscs_pkg;

    // ------------------------------------------------------------------
    // Clock rate and printed times
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_POR_MS = 100;
    localparam int T_CF2CD_MAX_NS = 800;
    localparam int T_CF2ST0_MAX_NS = 800;
    localparam int T_STATUS_MIN_US = 10;
    localparam int T_STATUS_MAX_US = 40;
    localparam int T_ERR_HOLD_US = 10;
    localparam int T_CD2UM_MIN_US = 18;
    localparam int T_CD2UM_MAX_US = 40;
    localparam int T_SERIAL_MAX_PERIOD_NS = 10;
    localparam int CD2CU_SERIAL_PERIODS = 4;
    localparam int USER_CLK_INIT_PERIODS = 299;

    // ------------------------------------------------------------------
    // Derived cycle counts (least times round up, longest round down)
    // ------------------------------------------------------------------
    localparam int POR_CYC_DEFAULT = (T_POR_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CF2CD_MAX_CYC = T_CF2CD_MAX_NS / CLK_PERIOD_NS;
    localparam int CF2ST0_MAX_CYC = T_CF2ST0_MAX_NS / CLK_PERIOD_NS;
    localparam int STATUS_MIN_CYC = (T_STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STATUS_MAX_CYC = T_STATUS_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int ERR_HOLD_CYC = (T_ERR_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_OSC_CYC = (T_CD2UM_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CD2CU_CYC = (CD2CU_SERIAL_PERIODS * T_SERIAL_MAX_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Widths, stream layout and reset values
    // ------------------------------------------------------------------
    localparam int TIMER_W = 22;
    localparam int WORD_W = 16;
    localparam int UCLK_CNT_W = 9;
    localparam logic [WORD_W-1:0] SYNC_WORD = 16'ha55a;
    localparam logic [WORD_W-1:0] RUN_ESCAPE = 16'h0000;
    localparam logic [3:0] PIN_RESET = 4'h0;

    // Bit positions of the synchronised pin bundle.
    localparam int PIN_REQ = 0;
    localparam int PIN_STATUS = 1;
    localparam int PIN_COMPLETE = 2;
    localparam int PIN_UCLK = 3;

    typedef enum logic [3:0] {
        SEQ_POR      = 4'b0000,
        SEQ_RESET    = 4'b0001,
        SEQ_RELEASE  = 4'b0010,
        SEQ_RECEIVE  = 4'b0011,
        SEQ_ERROR    = 4'b0100,
        SEQ_INITWAIT = 4'b0101,
        SEQ_INITOSC  = 4'b0110,
        SEQ_CLKEN    = 4'b0111,
        SEQ_USERCLK  = 4'b1000,
        SEQ_USER     = 4'b1001
    } pscs_state_t;

    typedef struct packed {
        logic autoRestart;
        logic userClock;
        logic compressed;
    } pscs_opt_t;

    typedef struct packed {
        logic valid;
        logic [WORD_W-1:0] data;
        logic [WORD_W-1:0] repeatCount;
    } pscs_word_t;

endpackage

// *** design/pscs_link_rx.sv ***
// Serial receiver that runs on the host's configuration clock.
// Assumes the host starts that clock only after the link reset has been released.
`timescale 1ns/1ps
module pscs_link_rx
    import pscs_pkg::*;
(
    input wire logic serialCfgClock,
    input wire logic linkRst_n,
    input wire logic serialCfgData,
    output logic [WORD_W-1:0] linkWord,
    output logic linkToggle
);

    // ------------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] shift_q;
    logic [$clog2(WORD_W)-1:0] bitCnt_q;
    logic [WORD_W-1:0] hold_q;
    logic toggle_q;
    logic [WORD_W-1:0] shift_d;

    // The next shift value, most significant bit first.
    assign shift_d = {shift_q[WORD_W-2:0], serialCfgData};

    // The link clock stands still outside frames, so a synchronous reset could never act;
    // the reset is asynchronous and released while the clock is known to be idle.
    always_ff @(posedge serialCfgClock or negedge linkRst_n) begin
        if (!linkRst_n) begin
            shift_q <= '0;
            bitCnt_q <= '0;
        end else begin
            shift_q <= shift_d;
            bitCnt_q <= bitCnt_q + 1'b1;
        end
    end

    // A full word is parked in the holding register and announced by a toggle.
    // The word stays stable for a whole word time, which covers the crossing delay.
    always_ff @(posedge serialCfgClock or negedge linkRst_n) begin
        if (!linkRst_n) begin
            hold_q <= '0;
            toggle_q <= 1'b0;
        end else if (&bitCnt_q) begin
            hold_q <= shift_d;
            toggle_q <= ~toggle_q;
        end
    end

    assign linkWord = hold_q;
    assign linkToggle = toggle_q;

endmodule

// *** tb/pscs_sequencer_chk.sv ***
// Checker on the sequencer pins: reset timing, completion and start-up.
// Assumes it is bound to pscs_sequencer and reads that module's ports only.
`timescale 1ns/1ps
module pscs_sequencer_chk
    import pscs_pkg::*;
#(
    parameter int POR_CYC = POR_CYC_DEFAULT,
    parameter logic [31:0] CFG_WORDS = 32'h0000_0400
)(
    input logic clk,
    input logic reset_n,
    input logic cfgRequest_n,
    input logic cfgStatusIn_n,
    input logic cfgStatusOut_n,
    input logic cfgStatusOe,
    input logic cfgCompleteIn,
    input logic cfgCompleteOut,
    input logic cfgCompleteOe,
    input logic serialCfgClock,
    input logic serialCfgData,
    input logic userStartupClock,
    input logic autoRestartEn,
    input logic userClockEn,
    input logic compressEn,
    input pscs_word_t cfgWord,
    input logic cfgError,
    input logic userMode
);
    localparam int UM_MAX = T_CD2UM_MAX_US * 1000 / CLK_PERIOD_NS;
    logic [31:0] lowCnt_q, hiCnt_q, doneCnt_q, sum_q, uEdge_q;
    logic [2:0] uSync_q;
    logic rel_q;
    // ----
    // Helper counters
    // ----
    // The counters wrap only after 2^32 cycles, far beyond any run.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {lowCnt_q, hiCnt_q, doneCnt_q, sum_q, uEdge_q} <= '0;
            uSync_q <= 3'h0;
            rel_q <= 1'b0;
        end else begin
            lowCnt_q <= cfgStatusOe ? lowCnt_q + 1 : 32'h0;
            hiCnt_q <= (cfgStatusOe && cfgRequest_n) ? hiCnt_q + 1 : 32'h0;
            doneCnt_q <= cfgCompleteOe ? 32'h0 : doneCnt_q + 1;
            uSync_q <= {uSync_q[1:0], userStartupClock};
            uEdge_q <= cfgCompleteOe ? 32'h0 : uEdge_q + 32'(uSync_q[1] & ~uSync_q[2]);
            rel_q <= rel_q | ~cfgStatusOe;
            if (cfgStatusOe) begin
                sum_q <= 32'h0;
            end else if (cfgWord.valid && cfgWord.data != SYNC_WORD) begin
                sum_q <= sum_q + 32'(cfgWord.repeatCount);
            end
        end
    end
    // ----
    // Properties
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_CF2CD: assert property ($fell(cfgRequest_n) |-> ##[1:32] cfgCompleteOe)
        else $error("completion not pulled low");
    AST_CF2ST: assert property ($fell(cfgRequest_n) |-> ##[1:32] cfgStatusOe)
        else $error("status not pulled low");
    AST_POR: assert property ($fell(cfgStatusOe) && !rel_q |-> lowCnt_q >= POR_CYC)
        else $error("power-on hold too short");
    AST_STMIN: assert property ($fell(cfgStatusOe) |-> lowCnt_q >= STATUS_MIN_CYC)
        else $error("status pulse too short");
    AST_STMAX: assert property (!(cfgError && !autoRestartEn) |-> hiCnt_q < POR_CYC + STATUS_MAX_CYC)
        else $error("status held too long");
    AST_DONE: assert property ($fell(cfgCompleteOe) |-> sum_q >= CFG_WORDS)
        else $error("completion released early");
    AST_REL: assert property (cfgCompleteOe && cfgWord.valid && sum_q + 32'(cfgWord.repeatCount) >= CFG_WORDS
        |-> ##[1:4] !cfgCompleteOe) else $error("completion not released");
    AST_UMOSC: assert property ($rose(userMode) && !userClockEn |-> doneCnt_q >= INIT_OSC_CYC && doneCnt_q <= UM_MAX)
        else $error("oscillator start-up time off");
    AST_UMCLK: assert property ($rose(userMode) && userClockEn |-> uEdge_q >= USER_CLK_INIT_PERIODS)
        else $error("user clock start-up too short");
    AST_UMPIN: assert property (userMode |-> !cfgStatusOe && !cfgCompleteOe)
        else $error("line low in user mode");
    AST_ERR: assert property ($rose(cfgError) |-> ##[0:2] cfgStatusOe)
        else $error("error without status low");
    AST_WORD: assert property (cfgWord.valid |-> cfgCompleteOe && !cfgStatusOe)
        else $error("word outside data stage");
    cover property ($rose(userMode));
    cover property ($rose(cfgError));
    cover property ($fell(cfgCompleteOe));
endmodule

bind pscs_sequencer pscs_sequencer_chk #(.POR_CYC(POR_CYC), .CFG_WORDS(CFG_WORDS)) chk (.*);

// *** tb/pscs_host_model.sv ***
// Host model: shifts 16-bit words MSB first on a 6 ns link clock.
// Assumes the bench calls send only while the device is receiving.
`timescale 1ns/1ps
module pscs_host_model (
    output logic serialCfgClock,
    output logic serialCfgData
);
    // ----
    // Serial shifter
    // ----
    // The clock rests low between words so the device sees no stray edge.
    initial begin
        serialCfgClock = 1'b0;
        serialCfgData = 1'b0;
    end
    // Data moves in the low phase, well clear of the rising edge.
    task automatic send(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            serialCfgData = w[i];
            #2 serialCfgClock = 1'b1;
            #3 serialCfgClock = 1'b0;
            #1;
        end
        serialCfgData = ~w[0];
        #100; // Idle gap so each word crosses before the next one lands.
    endtask
endmodule

// *** tb/pscs_sequencer_tb_top.sv ***
// Self-checking bench for the sequencer with a serial host model.
// Assumes pull-ups on the status and completion wires.
`timescale 1ns/1ps
module pscs_sequencer_tb_top
    import pscs_pkg::*;
;
    typedef struct packed {
        logic [15:0] w;
        logic [15:0] d;
        logic [15:0] r;
        logic b;
    } pscs_row_t;
    // Sent word beside the beat it should give; b low means no beat.
    localparam pscs_row_t ROWS [8] = '{
        '{16'ha55a, 16'h0000, 16'h0000, 1'b0},
        '{16'h1111, 16'h1111, 16'h0001, 1'b1},
        '{16'h0000, 16'h0000, 16'h0001, 1'b1},
        '{16'h3333, 16'h3333, 16'h0001, 1'b1},
        '{16'ha55a, 16'h0000, 16'h0000, 1'b0},
        '{16'h0000, 16'h0000, 16'h0000, 1'b0},
        '{16'h0002, 16'h0000, 16'h0002, 1'b1},
        '{16'h5678, 16'h5678, 16'h0001, 1'b1}
    };
    logic clk, reset_n, cfgRequest_n, autoRestartEn, userClockEn, compressEn, userStartupClock;
    logic cfgStatusOut_n, cfgStatusOe, cfgCompleteOut, cfgCompleteOe, cfgError, userMode;
    logic serialCfgClock, serialCfgData, cfgStatusIn_n, cfgCompleteIn;
    pscs_word_t cfgWord;
    pscs_word_t got[$];
    int fails, nTests, cyc, c, tDone;
    // Open-drain wires: pulled up unless the device drives them.
    assign cfgStatusIn_n = cfgStatusOe ? cfgStatusOut_n : 1'b1;
    assign cfgCompleteIn = cfgCompleteOe ? cfgCompleteOut : 1'b1;
    pscs_sequencer #(.POR_CYC(50), .CFG_WORDS(32'h0000_0003)) dut (.*);
    pscs_host_model host (.*);
    always #12.5 clk = ~clk;
    // Sync words are skipped so the check holds whether or not they give beats.
    always @(negedge clk) if (cfgWord.valid === 1'b1 && cfgWord.data !== SYNC_WORD) got.push_back(cfgWord);
    // A hang is cut short well past the expected eight thousand cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        nTests++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic waitSig(input int s, input logic v, input int lim);
        c = 0;
        while ((s == 0 ? cfgStatusOe : s == 1 ? cfgCompleteOe : userMode) !== v && c < lim) begin
            @(negedge clk);
            c++;
        end
    endtask
    task automatic runCfg(input int a, input int b);
        pscs_word_t g;
        got.delete();
        for (int i = a; i <= b; i++) host.send(ROWS[i].w);
        waitSig(1, 1'b0, 50);
        tDone = cyc;
        repeat (20) @(negedge clk);
        for (int i = a; i <= b; i++) begin
            if (ROWS[i].b) begin
                g = got.size() ? got.pop_front() : '0;
                chk({g.data, g.repeatCount}, {ROWS[i].d, ROWS[i].r});
            end
        end
        chk(32'(got.size()), 32'h0);
        chk(32'(cfgCompleteOe), 32'h0);
    endtask
    task automatic end_sim();
        if (fails == 0 && nTests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        {clk, reset_n, autoRestartEn, userClockEn, compressEn, userStartupClock} = '0;
        cfgRequest_n = 1'b1;
        {fails, nTests, cyc} = '0;
        @(posedge clk);
        @(negedge clk);
        chk(32'({cfgStatusOe, cfgCompleteOe, cfgError, userMode}), 32'hc);
        @(posedge clk) reset_n <= 1'b1;
        waitSig(0, 1'b0, 3000);
        chk(32'(c + 2 >= 50 + STATUS_MIN_CYC), 32'h1);
        repeat (40) @(negedge clk);
        runCfg(0, 3);
        waitSig(2, 1'b1, 2000);
        chk(32'(cyc - tDone >= INIT_OSC_CYC && cyc - tDone <= 1600), 32'h1);
        // Reconfigure from user mode, compressed, with the user start-up clock.
        @(posedge clk) {cfgRequest_n, compressEn, userClockEn, autoRestartEn} <= 4'h7;
        repeat (8) @(negedge clk);
        chk(32'({cfgStatusOe, cfgCompleteOe}), 32'h3);
        repeat (80) @(posedge clk);
        cfgRequest_n <= 1'b1;
        waitSig(0, 1'b0, 1700);
        chk(32'({userMode, c <= 1600}), 32'h1);
        repeat (1600) @(negedge clk);
        runCfg(4, 7);
        repeat (10) @(posedge clk);
        for (int i = 0; i < 310; i++) begin
            @(posedge clk) userStartupClock <= 1'b1;
            repeat (4) @(posedge clk);
            userStartupClock <= 1'b0;
            repeat (3) @(posedge clk);
            if (i == 297) chk(32'(userMode), 32'h0);
        end
        @(negedge clk);
        chk(32'(userMode), 32'h1);
        // A bad first word must raise an error and restart by itself.
        @(posedge clk) cfgRequest_n <= 1'b0;
        repeat (88) @(posedge clk);
        cfgRequest_n <= 1'b1;
        waitSig(0, 1'b0, 1700);
        repeat (1600) @(negedge clk);
        host.send(16'h1234);
        repeat (20) @(negedge clk);
        chk(32'({cfgError, cfgStatusOe}), 32'h3);
        @(posedge clk) {compressEn, userClockEn} <= 2'b00;
        waitSig(0, 1'b0, 1700);
        chk(32'(c <= 1600), 32'h1);
        repeat (40) @(negedge clk);
        runCfg(0, 3);
        end_sim();
    end
endmodule
